// ===== core/mco_pkg.sv
// constants and carrier types for the microcontroller clock output block
package mco_pkg;

  // ****************************************************************
  // register map and field layout
  // ****************************************************************
  localparam logic [6:0] CTRL_ADDR   = 7'h0a;
  localparam logic [7:0] CTRL_RST    = 8'h06;  // 1 MHz, no tail, lf off
  localparam int         SEL_LSB     = 0;
  localparam int         LFC_BIT     = 3;
  localparam int         TAIL_LSB    = 4;
  localparam logic [2:0] SEL_LF      = 3'h7;   // 32.768 kHz setting

  // ****************************************************************
  // timing: crystal and system rates
  // ****************************************************************
  localparam int XTAL_HZ = 30_000_000;
  localparam int SYS_HZ  = 10_000_000;
  // phase advance per system cycle, in half crystal periods
  localparam logic [6:0] PHASE_INC = 7'((2 * XTAL_HZ) / SYS_HZ);

  // output period for each select code, in half crystal periods
  localparam logic [6:0] PER_30M = 7'h02;
  localparam logic [6:0] PER_15M = 7'h04;
  localparam logic [6:0] PER_10M = 7'h06;
  localparam logic [6:0] PER_4M  = 7'h0f;
  localparam logic [6:0] PER_3M  = 7'h14;
  localparam logic [6:0] PER_2M  = 7'h1e;
  localparam logic [6:0] PER_1M  = 7'h3c;

  // clock tail lengths in output cycles
  localparam logic [9:0] TAIL_128 = 10'h080;
  localparam logic [9:0] TAIL_256 = 10'h100;
  localparam logic [9:0] TAIL_512 = 10'h200;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_AWAKE = 4'b0001,  // select field drives the output
    ST_TAIL  = 4'b0010,  // extra cycles before shutdown
    ST_LFS   = 4'b0100,  // sleeping, low-frequency clock out
    ST_OFF   = 4'b1000   // sleeping, output stopped
  } mco_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } mco_reg_req_t;

  typedef struct packed {
    logic       xtal_en;
    logic       lf_src;
    logic       sleeping;
  } mco_status_t;

endpackage : mco_pkg

// ===== core/mco_clock_out.sv
// microcontroller clock output: divider, sleep fallback, tail, irq hold
// ****************************************************************
// Notes on behaviour
// - three-bit select picks 30,15,10,4,3,2,1 MHz or 32.768 kHz; at the 10 MHz pin rate codes 0 and 2 hold the pin at a fixed level, code 1 gives 5 MHz
// - all settings but the low one come from dividing the crystal
// - low clock comes from rc oscillator or external 32 kHz crystal
// - after reset the output runs at 1 MHz, register value 06h
// - in sleep with low clock enabled, 32.768 kHz regardless of select
// - idle, transmit and receive output the selected frequency
// - crystal oscillator is switched off while sleeping
// - in sleep with low clock disabled the output stops
// - tail field adds 0, 128, 256 or 512 cycles before shutdown
// - pending interrupt keeps clock running until status is read
// - sleep with interrupt outstanding keeps crystal on until cleared
// - register: tail 5:4, low clock enable 3, select 2:0, 7:6 zero
// ****************************************************************
`timescale 1ns/100ps

module mco_clock_out (
  // clock and reset
  input  wire logic                 sys_clk_in,
  input  wire logic                 rst_b_in,
  // register port
  input  wire mco_pkg::mco_reg_req_t reg_req_in,
  output logic [7:0]                reg_rdata_out,
  // power mode and interrupt state from the chip
  input  wire logic                 sleep_cmd_in,
  input  wire logic                 irq_pending_in,
  // low-frequency clock from rc oscillator or 32 kHz crystal
  input  wire logic                 lf_clk_in,
  // clock to the microcontroller and status
  output logic                      clock_output_pin_out,
  output mco_pkg::mco_status_t      status_out
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [1:0]          lf_sync;
    logic [5:0]          ctrl;
    logic [7:0]          rdata;
    mco_pkg::mco_state_t st;
    logic [6:0]          phase;
    logic                xtal_prev;
    logic [9:0]          tail_cnt;
    logic                lf_src;
    logic                pin;
  } mco_regs_t;

  mco_regs_t  state_reg;
  mco_regs_t  state_next;
  logic [1:0] rst_sync_reg;
  logic       rst_n_int;

  // select code to output period, in half crystal periods
  function automatic logic [6:0] sel_period(input logic [2:0] sel);
    case (sel)
      3'h0:    sel_period = mco_pkg::PER_30M;
      3'h1:    sel_period = mco_pkg::PER_15M;
      3'h2:    sel_period = mco_pkg::PER_10M;
      3'h3:    sel_period = mco_pkg::PER_4M;
      3'h4:    sel_period = mco_pkg::PER_3M;
      3'h5:    sel_period = mco_pkg::PER_2M;
      default: sel_period = mco_pkg::PER_1M;
    endcase
  endfunction

  // tail field to number of extra cycles
  function automatic logic [9:0] tail_len(input logic [1:0] code);
    case (code)
      2'h1:    tail_len = mco_pkg::TAIL_128;
      2'h2:    tail_len = mco_pkg::TAIL_256;
      2'h3:    tail_len = mco_pkg::TAIL_512;
      default: tail_len = 10'h000;
    endcase
  endfunction

  // ****************************************************************
  // reset release: async assert, two-flop release
  // ****************************************************************
  // kept apart from the state struct: it is reset by the raw pin
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n_int = rst_sync_reg[1];

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  always_comb begin
    logic [2:0] sel;
    logic       lfc_en;
    logic [1:0] tail_code;
    logic [6:0] per;
    logic [6:0] ph_sum;
    logic       xtal_val;
    logic       xtal_rise;
    logic       lf_val;
    logic       sleep_eff;
    logic       want_lf;
    logic       run;
    logic       src_val;
    logic       xtal_on;
    logic       quiet;
    sel        = '0;
    lfc_en     = 1'b0;
    tail_code  = '0;
    per        = '0;
    ph_sum     = '0;
    xtal_val   = 1'b0;
    xtal_rise  = 1'b0;
    lf_val     = 1'b0;
    sleep_eff  = 1'b0;
    want_lf    = 1'b0;
    run        = 1'b0;
    src_val    = 1'b0;
    xtal_on    = 1'b0;
    quiet      = 1'b0;
    state_next = state_reg;

    sel       = state_reg.ctrl[mco_pkg::SEL_LSB +: 3];
    lfc_en    = state_reg.ctrl[mco_pkg::LFC_BIT];
    tail_code = state_reg.ctrl[mco_pkg::TAIL_LSB +: 2];

    // pin input through two flops; only the second is read
    state_next.lf_sync = {state_reg.lf_sync[0], lf_clk_in};
    lf_val = state_reg.lf_sync[1];

    // sleep only takes hold once no interrupt is pending
    sleep_eff = sleep_cmd_in & ~irq_pending_in;

    // register write and registered read
    if (reg_req_in.wr && reg_req_in.addr == mco_pkg::CTRL_ADDR) begin
      state_next.ctrl = reg_req_in.wdata[5:0];
    end
    if (reg_req_in.rd) begin
      state_next.rdata = (reg_req_in.addr == mco_pkg::CTRL_ADDR) ?
                         {2'b00, state_reg.ctrl} : 8'h00;
    end

    // crystal phase accumulator; runs only while crystal is on
    per     = sel_period(sel);
    xtal_on = (state_reg.st == mco_pkg::ST_AWAKE) ||
              (state_reg.st == mco_pkg::ST_TAIL);
    if (xtal_on) begin
      ph_sum = state_reg.phase + mco_pkg::PHASE_INC;
      state_next.phase = 7'(ph_sum % per);
    end else begin
      state_next.phase = 7'h00;
    end
    // a stopped crystal leaves its divided clock low
    xtal_val = xtal_on &&
               ({state_reg.phase, 1'b0} < {1'b0, per});
    state_next.xtal_prev = xtal_val;
    xtal_rise = xtal_val & ~state_reg.xtal_prev;

    // level feeding the pin; sleep entry waits for it to be low so the
    // crystal never stops in the middle of a high half
    src_val = state_reg.lf_src ? lf_val : xtal_val;
    quiet   = !src_val;

    // mode sequencing
    case (state_reg.st)
      mco_pkg::ST_AWAKE: begin
        if (sleep_eff && lfc_en) begin
          if (quiet) begin
            state_next.st = mco_pkg::ST_LFS;
          end
        end else if (sleep_eff) begin
          state_next.st       = mco_pkg::ST_TAIL;
          state_next.tail_cnt = 10'h000;
        end
      end
      mco_pkg::ST_TAIL: begin
        if (!sleep_eff) begin
          state_next.st = mco_pkg::ST_AWAKE;
        end else if (lfc_en) begin
          if (quiet) begin
            state_next.st = mco_pkg::ST_LFS;
          end
        end else if (state_reg.tail_cnt >= tail_len(tail_code)) begin
          if (quiet) begin
            state_next.st = mco_pkg::ST_OFF;
          end
        end else if (xtal_rise) begin
          state_next.tail_cnt = state_reg.tail_cnt + 10'h001;
        end
      end
      mco_pkg::ST_LFS: begin
        if (!sleep_eff) begin
          state_next.st = mco_pkg::ST_AWAKE;
        end else if (!lfc_en) begin
          if (quiet) begin
            state_next.st = mco_pkg::ST_OFF;
          end
        end
      end
      mco_pkg::ST_OFF: begin
        if (!sleep_eff) begin
          state_next.st = mco_pkg::ST_AWAKE;
        end else if (lfc_en) begin
          state_next.st = mco_pkg::ST_LFS;
        end
      end
      default: state_next.st = mco_pkg::ST_AWAKE;
    endcase

    // wanted source and whether the pin may toggle
    want_lf = (state_reg.st == mco_pkg::ST_LFS) ||
              (state_reg.st == mco_pkg::ST_AWAKE &&
               sel == mco_pkg::SEL_LF);
    run     = (state_reg.st != mco_pkg::ST_OFF);

    // swap source only while pin and new source are both low
    if (want_lf != state_reg.lf_src && !state_reg.pin &&
        !(want_lf ? lf_val : xtal_val)) begin
      state_next.lf_src = want_lf;
    end
    // pin follows source; a stop waits for a low level
    if (run) begin
      if (state_reg.lf_src == want_lf) begin
        state_next.pin = src_val;
      end else begin
        state_next.pin = state_reg.pin & src_val;
      end
    end else begin
      state_next.pin = 1'b0;
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge sys_clk_in or negedge rst_n_int) begin
    if (!rst_n_int) begin
      state_reg.lf_sync   <= 2'b00;
      state_reg.ctrl      <= mco_pkg::CTRL_RST[5:0];
      state_reg.rdata     <= 8'h00;
      state_reg.st        <= mco_pkg::ST_AWAKE;
      state_reg.phase     <= 7'h00;
      state_reg.xtal_prev <= 1'b0;
      state_reg.tail_cnt  <= 10'h000;
      state_reg.lf_src    <= 1'b0;
      state_reg.pin       <= 1'b0;
    end else begin
      state_reg.lf_sync   <= state_next.lf_sync;
      state_reg.ctrl      <= state_next.ctrl;
      state_reg.rdata     <= state_next.rdata;
      state_reg.st        <= state_next.st;
      state_reg.phase     <= state_next.phase;
      state_reg.xtal_prev <= state_next.xtal_prev;
      state_reg.tail_cnt  <= state_next.tail_cnt;
      state_reg.lf_src    <= state_next.lf_src;
      state_reg.pin       <= state_next.pin;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign reg_rdata_out        = state_reg.rdata;
  assign clock_output_pin_out = state_reg.pin;
  // crystal stays on while awake or in the tail
  assign status_out = '{
    xtal_en:  (state_reg.st == mco_pkg::ST_AWAKE) ||
              (state_reg.st == mco_pkg::ST_TAIL),
    lf_src:   state_reg.lf_src,
    sleeping: (state_reg.st == mco_pkg::ST_LFS) ||
              (state_reg.st == mco_pkg::ST_OFF)
  };

endmodule // mco_clock_out

// ===== tb/mco_mcu_model.sv
// microcontroller model that runs from the clock output pin
`timescale 1ns/100ps
module mco_mcu_model (
  // clock received from the radio
  input  wire logic   mcu_clk_in,
  // processor cycles seen so far
  output logic [15:0] rise_cnt_out
);
  // each rising edge is one processor cycle
  initial rise_cnt_out = 16'h0000;
  always @(posedge mcu_clk_in) rise_cnt_out <= rise_cnt_out + 16'h0001;
endmodule // mco_mcu_model

// ===== tb/mco_clock_out_sva.sv
// port checker for the clock output block
`timescale 1ns/100ps
module mco_clock_out_sva (
  // clock and reset
  input wire logic                  sys_clk_in,
  input wire logic                  rst_b_in,
  // register port
  input wire mco_pkg::mco_reg_req_t reg_req_in,
  input wire logic [7:0]            reg_rdata_out,
  // chip state, clocks and status
  input wire logic                  sleep_cmd_in,
  input wire logic                  irq_pending_in,
  input wire logic                  lf_clk_in,
  input wire logic                  clock_output_pin_out,
  input wire mco_pkg::mco_status_t  status_out
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  // interrupt keeps the chip awake with its crystal on
  property p_irq_wake; irq_pending_in |=> !status_out.sleeping; endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("asleep, irq");
  property p_irq_xtal; irq_pending_in |=> status_out.xtal_en; endproperty
  a_irq_xtal: assert property (p_irq_xtal) else $error("xtal off");
  // sleeping means crystal off; no sleep when not commanded
  property p_slp_xtal; status_out.sleeping |-> !status_out.xtal_en; endproperty
  a_slp_xtal: assert property (p_slp_xtal) else $error("xtal on");
  property p_awake; !sleep_cmd_in |=> !status_out.sleeping; endproperty
  a_awake: assert property (p_awake) else $error("slept uncommanded");
  // stopped output is held low
  property p_off_low;
    status_out.sleeping && !status_out.lf_src |-> !clock_output_pin_out;
  endproperty
  a_off_low: assert property (p_off_low) else $error("pin not low");
  // source switches only across a low output
  property p_sw_low;
    $changed(status_out.lf_src) |->
      !clock_output_pin_out && !$past(clock_output_pin_out);
  endproperty
  a_sw_low: assert property (p_sw_low) else $error("switch glitch");
  // read data: unused bits, unmapped address, hold between reads
  property p_rd_top;
    reg_req_in.rd && reg_req_in.addr == mco_pkg::CTRL_ADDR
      |=> reg_rdata_out[7:6] == 2'b00;
  endproperty
  a_rd_top: assert property (p_rd_top) else $error("bits 7:6 set");
  property p_rd_other;
    reg_req_in.rd && reg_req_in.addr != mco_pkg::CTRL_ADDR
      |=> reg_rdata_out == 8'h00;
  endproperty
  a_rd_other: assert property (p_rd_other) else $error("bad rdata");
  property p_rd_hold;
    !reg_req_in.rd && !$past(reg_req_in.rd) |=> $stable(reg_rdata_out);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("rdata moved");
  // main scenarios
  c_lfs: cover property (status_out.sleeping && status_out.lf_src);
  c_off: cover property (status_out.sleeping && !status_out.lf_src);
  c_hold: cover property (sleep_cmd_in && irq_pending_in);
endmodule // mco_clock_out_sva

bind mco_clock_out mco_clock_out_sva i_sva (.sys_clk_in, .rst_b_in,
  .reg_req_in, .reg_rdata_out, .sleep_cmd_in, .irq_pending_in,
  .lf_clk_in, .clock_output_pin_out, .status_out);

// ===== tb/tb_mco_clock_out.sv
// self-checking bench for the clock output block
`timescale 1ns/100ps
module tb_mco_clock_out;
  logic                  sys_clk_in;
  logic                  rst_b_in;
  mco_pkg::mco_reg_req_t reg_req_in;
  logic [7:0]            reg_rdata_out;
  logic                  sleep_cmd_in;
  logic                  irq_pending_in;
  logic                  lf_clk_in;
  logic                  clock_output_pin_out;
  mco_pkg::mco_status_t  status_out;
  logic [15:0]           rise_cnt;
  logic [15:0]           n;
  int                    err_total;
  int                    cmp_count;

  mco_clock_out i_dut (.sys_clk_in, .rst_b_in, .reg_req_in, .reg_rdata_out,
    .sleep_cmd_in, .irq_pending_in, .lf_clk_in, .clock_output_pin_out,
    .status_out);
  mco_mcu_model i_mcu (.mcu_clk_in(clock_output_pin_out),
    .rise_cnt_out(rise_cnt));

  // ****************
  // clocks and helpers
  // ****************
  initial begin
    sys_clk_in = 1'b0;
    forever #50 sys_clk_in = ~sys_clk_in;
  end
  // low clock near 32.768 kHz, unrelated to the system clock
  initial begin
    lf_clk_in = 1'b0;
    forever #15259 lf_clk_in = ~lf_clk_in;
  end
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic wr(logic [6:0] a, logic [7:0] d);
    reg_req_in = '{1'b1, 1'b0, a, d};
    tick(1);
    reg_req_in = '0;
    tick(1);
  endtask
  task automatic rd(logic [6:0] a, logic [7:0] exp);
    reg_req_in = '{1'b0, 1'b1, a, 8'h00};
    tick(1);
    reg_req_in = '0;
    tick(1);
    cmp("rdata", {8'h00, exp}, {8'h00, reg_rdata_out});
  endtask
  // rising edges the microcontroller sees over k cycles
  task automatic rises(int k);
    n = rise_cnt;
    tick(k);
    n = rise_cnt - n;
  endtask
  task automatic wait_slp(logic exp);
    for (int i = 0; i < 4000; i++) begin
      if (status_out.sleeping === exp) return;
      tick(1);
    end
    err_total++;
    $display("[FAIL] sleeping exp %h got %h", exp, status_out.sleeping);
    give_verdict();
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic t_regs();
    rd(7'h0a, 8'h06);
    rises(100);
    cmp("1 MHz", 16'h000a, n);
    wr(7'h0a, 8'hff);
    rd(7'h0a, 8'h3f);
    wr(7'h0b, 8'h00);
    rd(7'h0a, 8'h3f);
    rd(7'h0b, 8'h00);
  endtask
  // a handover to the low clock waits up to half its period
  task automatic t_freq();
    logic [15:0] exp[4] = '{16'd40, 16'd30, 16'd20, 16'd10};
    for (int s = 3; s < 7; s++) begin
      wr(7'h0a, 8'(s));
      tick(200);
      rises(100);
      cmp("rate", exp[s-3], n);
    end
    wr(7'h0a, 8'h07);
    rises(3052);
    cmp("lf rate", 16'h0001, 16'(n >= 9 && n <= 11));
  endtask
  task automatic t_lf_sleep();
    wr(7'h0a, 8'h0e);
    sleep_cmd_in = 1'b1;
    wait_slp(1'b1);
    tick(200);
    cmp("xtal", 16'h0000, 16'(status_out.xtal_en));
    cmp("lf src", 16'h0001, 16'(status_out.lf_src));
    rises(3052);
    cmp("lf out", 16'h0001, 16'(n >= 9 && n <= 11));
    sleep_cmd_in = 1'b0;
    wait_slp(1'b0);
    cmp("xtal", 16'h0001, 16'(status_out.xtal_en));
    tick(200);
    cmp("lf src", 16'h0000, 16'(status_out.lf_src));
  endtask
  task automatic t_tail();
    logic [15:0] len[4] = '{16'd0, 16'd128, 16'd256, 16'd512};
    for (int t = 0; t < 4; t++) begin
      wr(7'h0a, 8'((t << 4) | 5));
      n = rise_cnt;
      sleep_cmd_in = 1'b1;
      wait_slp(1'b1);
      n = rise_cnt - n;
      cmp("tail", 16'h0001, 16'(n >= len[t] && n <= len[t] + 1));
      rises(60);
      cmp("stopped", 16'h0000, n);
      sleep_cmd_in = 1'b0;
      wait_slp(1'b0);
    end
  endtask
  task automatic t_irq();
    irq_pending_in = 1'b1;
    sleep_cmd_in = 1'b1;
    rises(100);
    cmp("held", 16'h0014, n);
    cmp("xtal", 16'h0001, 16'(status_out.xtal_en));
    irq_pending_in = 1'b0;
    wait_slp(1'b1);
    irq_pending_in = 1'b1;
    tick(2);
    cmp("woken", 16'h0000, 16'(status_out.sleeping));
    irq_pending_in = 1'b0;
    sleep_cmd_in = 1'b0;
    tick(5);
  endtask

  initial begin
    err_total = 0;
    cmp_count = 0;
    rst_b_in = 1'b0;
    reg_req_in = '0;
    sleep_cmd_in = 1'b0;
    irq_pending_in = 1'b0;
    tick(8);
    rst_b_in = 1'b1;
    tick(3);
    t_regs();
    t_freq();
    t_lf_sleep();
    t_tail();
    t_irq();
    give_verdict();
  end
endmodule // tb_mco_clock_out
